// ===== psei_defs.svh
// Command codes, field positions and reset values for the event interrupt block
`ifndef PSEI_DEFS_SVH
`define PSEI_DEFS_SVH

`define PSEI_CMD_SUMMARY 8'h00
`define PSEI_CMD_MASK 8'h01
`define PSEI_CMD_PWR 8'h02
`define PSEI_CMD_PWR_CLR 8'h03
`define PSEI_CMD_DET 8'h04
`define PSEI_CMD_DET_CLR 8'h05

`define PSEI_MASK_RST 8'h80
`define PSEI_SUMMARY_RST 8'h80
`define PSEI_EVENT_RST 8'h00
`define PSEI_BYTE_ZERO 8'h00
`define PSEI_CHAN_ZERO 4'h0

`define PSEI_SUM_PEC 0
`define PSEI_SUM_PGC 1
`define PSEI_SUM_DISC 2
`define PSEI_SUM_DETECT_CYCLE_ANY 3
`define PSEI_SUM_CLASS_CYCLE_ANY 4
`define PSEI_SUM_OVLD 5
`define PSEI_SUM_START 6
`define PSEI_SUM_SUPPLY 7

`define PSEI_LO_HI 3
`define PSEI_LO_LO 0
`define PSEI_HI_HI 7
`define PSEI_HI_LO 4
`define PSEI_HI_OFS 4

`endif

// ===== psei_pkg.sv
// Types shared by the event interrupt block
package psei_pkg;
  typedef logic [7:0] psei_byte_t;
  typedef logic [3:0] psei_chan_t;
endpackage

// ===== psei_event_irq.sv
// Per-channel event latching, summary register and interrupt line for four channels
`timescale 1ns/1ps
`include "psei_defs.svh"

// Overview of operation
// [RULE1] Summary bit 0 is the OR of the four power-enable change bits.
// [RULE2] Read/write mask at command 01h; a zero bit blocks that cause from the line.
// [RULE3] Summary bits follow events whatever the mask holds; mask gates only the line.
// [RULE4] The line asserts only when the global gate input is also high.
// [RULE5] Mask bits 7..0: supply, start, overcurrent, class, detect, disconnect, pg, pe.
// [RULE6] Mask resets to 80h: supply bit set, all others clear.
// [RULE7] Power events read at 02h plainly and at 03h with clear on read.
// [RULE8] Detection events read at 04h plainly and at 05h with clear on read.
// [RULE9] A clearing read returns the value then clears the whole register.
// [RULE10] A clearing read of the causing register releases the interrupt line.
// [RULE11] Power events: bits 7..4 power-good changes, 3..0 power-enable changes, reset 0.
// [RULE12] Each event bit belongs to one channel and sets high on its event.
// [RULE13] A channel's detection event bits clear when that channel turns off.
// [RULE14] Any set event bit shows in the matching summary bit.
// [RULE15] Summary bits 7..1 are OR of their sources; bit 7 resets to 1.
// [RULE16] Summary clears through clearing reads or the reset-register summary clear.
// [RULE17] Detection bits 7..4 class, 3..0 detect; change-only modes flag changes only.
// [RULE18] Active-low line asserts while a summary bit, its mask and the gate are set.
// [RULE19] An event in the same cycle as a clearing read stays latched.
// [RULE20] Host reads summary, then clearing aliases until the line releases.
module psei_event_irq (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire psei_pkg::psei_byte_t cmd_code,
  input wire psei_pkg::psei_byte_t cmd_wdata,
  input wire psei_pkg::psei_chan_t power_enable_change_ch,
  input wire psei_pkg::psei_chan_t power_good_change_ch,
  input wire psei_pkg::psei_chan_t class_cycle_ch,
  input wire psei_pkg::psei_chan_t class_changed_ch,
  input wire psei_pkg::psei_chan_t detect_cycle_ch,
  input wire psei_pkg::psei_chan_t detect_changed_ch,
  input wire psei_pkg::psei_chan_t channel_off_ch,
  input wire logic class_change_only_mode,
  input wire logic detect_change_only_mode,
  input wire logic supply_fault_any,
  input wire logic start_fault_any,
  input wire logic overcurrent_fault_any,
  input wire logic disconnect_any,
  input wire logic irq_global_gate,
  input wire logic summary_clear,
  output psei_pkg::psei_byte_t rd_data_ff,
  output logic rd_valid_ff,
  output logic int_n_ff
);
  import psei_pkg::*;

  psei_byte_t irq_cause_mask_ff;
  psei_byte_t power_change_events_ff;
  psei_byte_t detect_class_events_ff;
  psei_byte_t summary_ff;

  psei_byte_t nxt_power_events;
  psei_byte_t nxt_detect_events;
  psei_byte_t nxt_summary;
  psei_byte_t nxt_rd_data;
  psei_byte_t pwr_set;
  psei_byte_t det_set;
  psei_byte_t det_keep;
  psei_chan_t cls_src;
  psei_chan_t det_src;
  logic rd_req;
  logic wr_req;
  logic pwr_clr;
  logic det_clr;
  logic nxt_int_n;

  assign rd_req = cmd_valid && !cmd_write;
  assign wr_req = cmd_valid && cmd_write;

  // Clearing reads and the summary clear wipe the whole register
  assign pwr_clr = (rd_req && (cmd_code == `PSEI_CMD_PWR_CLR)) || summary_clear; // [RULE9]
  assign det_clr = (rd_req && (cmd_code == `PSEI_CMD_DET_CLR)) || summary_clear; // [RULE16]

  // Change-only modes pick which per-channel strobe feeds each bit
  assign cls_src = class_change_only_mode ? class_changed_ch : class_cycle_ch; // [RULE17]
  assign det_src = detect_change_only_mode ? detect_changed_ch : detect_cycle_ch; // [RULE17]

  assign pwr_set = {power_good_change_ch, power_enable_change_ch}; // [RULE11]
  assign det_set = {cls_src, det_src}; // [RULE12]

  // Turning a channel off drops both its class and detect bits
  assign det_keep = ~{channel_off_ch, channel_off_ch}; // [RULE13]

  always_comb begin
    // Set is applied after the clear so a coincident event survives the read
    nxt_power_events = power_change_events_ff;
    if (pwr_clr) begin
      nxt_power_events = `PSEI_EVENT_RST;
    end
    nxt_power_events = nxt_power_events | pwr_set; // [RULE19]
  end

  always_comb begin
    nxt_detect_events = detect_class_events_ff & det_keep;
    if (det_clr) begin
      nxt_detect_events = `PSEI_EVENT_RST;
    end
    nxt_detect_events = nxt_detect_events | det_set; // [RULE19]
  end

  always_comb begin
    // Summary is built from next event state so it lines up with the event registers
    nxt_summary = `PSEI_BYTE_ZERO;
    nxt_summary[`PSEI_SUM_PEC] = |nxt_power_events[`PSEI_LO_HI:`PSEI_LO_LO]; // [RULE1]
    nxt_summary[`PSEI_SUM_PGC] = |nxt_power_events[`PSEI_HI_HI:`PSEI_HI_LO]; // [RULE15]
    nxt_summary[`PSEI_SUM_DETECT_CYCLE_ANY] = |nxt_detect_events[`PSEI_LO_HI:`PSEI_LO_LO]; // [RULE14]
    nxt_summary[`PSEI_SUM_CLASS_CYCLE_ANY] = |nxt_detect_events[`PSEI_HI_HI:`PSEI_HI_LO]; // [RULE14]
    nxt_summary[`PSEI_SUM_DISC] = disconnect_any; // [RULE15]
    nxt_summary[`PSEI_SUM_OVLD] = overcurrent_fault_any; // [RULE15]
    nxt_summary[`PSEI_SUM_START] = start_fault_any; // [RULE15]
    nxt_summary[`PSEI_SUM_SUPPLY] = supply_fault_any; // [RULE15]
  end

  // Mask only feeds the line; summary never looks at it
  assign nxt_int_n = !(irq_global_gate && |(nxt_summary & irq_cause_mask_ff)); // [RULE18] [RULE5]

  always_comb begin
    nxt_rd_data = `PSEI_BYTE_ZERO;
    unique case (cmd_code)
      `PSEI_CMD_SUMMARY: begin
        nxt_rd_data = summary_ff;
      end
      `PSEI_CMD_MASK: begin
        nxt_rd_data = irq_cause_mask_ff;
      end
      `PSEI_CMD_PWR, `PSEI_CMD_PWR_CLR: begin
        nxt_rd_data = power_change_events_ff; // [RULE7]
      end
      `PSEI_CMD_DET, `PSEI_CMD_DET_CLR: begin
        nxt_rd_data = detect_class_events_ff; // [RULE8]
      end
      default: begin
        nxt_rd_data = `PSEI_BYTE_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_cause_mask_ff <= `PSEI_MASK_RST; // [RULE6]
    end else if (wr_req && (cmd_code == `PSEI_CMD_MASK)) begin
      irq_cause_mask_ff <= cmd_wdata; // [RULE2]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      power_change_events_ff <= `PSEI_EVENT_RST;
    end else begin
      power_change_events_ff <= nxt_power_events; // [RULE11]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      detect_class_events_ff <= `PSEI_EVENT_RST;
    end else begin
      detect_class_events_ff <= nxt_detect_events; // [RULE17]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      summary_ff <= `PSEI_SUMMARY_RST; // [RULE15]
    end else begin
      summary_ff <= nxt_summary; // [RULE3]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_n_ff <= 1'b1;
    end else begin
      int_n_ff <= nxt_int_n; // [RULE4]
    end
  end

  // Read data is the pre-clear value; the clear lands on the same edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= `PSEI_BYTE_ZERO;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        rd_data_ff <= nxt_rd_data; // [RULE9]
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  pec_summary_or_a: assert property ( // [RULE1]
    summary_ff[`PSEI_SUM_PEC] == |power_change_events_ff[`PSEI_LO_HI:`PSEI_LO_LO])
    else $error("power enable summary bit differs from its event bits");

  pgc_summary_or_a: assert property ( // [RULE14]
    summary_ff[`PSEI_SUM_PGC] == |power_change_events_ff[`PSEI_HI_HI:`PSEI_HI_LO] &&
    summary_ff[`PSEI_SUM_CLASS_CYCLE_ANY] == |detect_class_events_ff[`PSEI_HI_HI:`PSEI_HI_LO] &&
    summary_ff[`PSEI_SUM_DETECT_CYCLE_ANY] == |detect_class_events_ff[`PSEI_LO_HI:`PSEI_LO_LO])
    else $error("summary bit differs from its event register");

  mask_write_a: assert property ( // [RULE2]
    wr_req && cmd_code == `PSEI_CMD_MASK |=> irq_cause_mask_ff == $past(cmd_wdata))
    else $error("mask write not stored");

  status_ignores_mask_a: assert property ( // [RULE3]
    power_enable_change_ch != `PSEI_CHAN_ZERO |=> summary_ff[`PSEI_SUM_PEC])
    else $error("summary bit not set by event");

  gate_blocks_line_a: assert property ( // [RULE4]
    !irq_global_gate |=> int_n_ff)
    else $error("interrupt line asserted with gate low");

  line_asserts_a: assert property ( // [RULE18]
    irq_global_gate && |(nxt_summary & irq_cause_mask_ff) |=> !int_n_ff ##0
    !int_n_ff[*1])
    else $error("interrupt line not asserted for masked-in cause");

  plain_read_a: assert property ( // [RULE7]
    rd_req && cmd_code == `PSEI_CMD_PWR && !summary_clear |=>
    rd_valid_ff && rd_data_ff == $past(power_change_events_ff) &&
    power_change_events_ff == ($past(power_change_events_ff) | $past(pwr_set)))
    else $error("plain power event read changed data or returned wrong value");

  det_plain_read_a: assert property ( // [RULE8]
    rd_req && cmd_code == `PSEI_CMD_DET |=> rd_data_ff == $past(detect_class_events_ff))
    else $error("detection event read returned wrong value");

  clear_read_a: assert property ( // [RULE9]
    rd_req && cmd_code == `PSEI_CMD_PWR_CLR && pwr_set == `PSEI_BYTE_ZERO |=>
    power_change_events_ff == `PSEI_EVENT_RST && rd_data_ff == $past(power_change_events_ff))
    else $error("clearing read did not clear power events");

  clear_releases_a: assert property ( // [RULE10]
    rd_req && cmd_code == `PSEI_CMD_PWR_CLR && pwr_set == `PSEI_BYTE_ZERO &&
    nxt_detect_events == `PSEI_BYTE_ZERO && !supply_fault_any && !start_fault_any &&
    !overcurrent_fault_any && !disconnect_any |=> int_n_ff)
    else $error("clearing read did not release interrupt line");

  chan_off_clear_a: assert property ( // [RULE13]
    channel_off_ch[0] && !det_set[0] && !det_set[`PSEI_HI_OFS] |=>
    !detect_class_events_ff[0] && !detect_class_events_ff[`PSEI_HI_OFS])
    else $error("channel off did not clear its detection bits");

  summary_clear_a: assert property ( // [RULE16]
    summary_clear && pwr_set == `PSEI_BYTE_ZERO && det_set == `PSEI_BYTE_ZERO |=>
    power_change_events_ff == `PSEI_EVENT_RST && detect_class_events_ff == `PSEI_EVENT_RST)
    else $error("summary clear left event bits set");

  set_wins_a: assert property ( // [RULE19]
    pwr_clr && power_good_change_ch[0] |=> power_change_events_ff[`PSEI_HI_OFS] ##1
    power_change_events_ff[`PSEI_HI_OFS] || $past(pwr_clr))
    else $error("event lost during clearing read");

  det_clear_read_a: assert property ( // [RULE8]
    rd_req && cmd_code == `PSEI_CMD_DET_CLR && det_set == `PSEI_BYTE_ZERO |=>
    detect_class_events_ff == `PSEI_EVENT_RST && rd_data_ff == $past(detect_class_events_ff))
    else $error("clearing read did not clear detection events");

  read_valid_a: assert property ( // [RULE7]
    rd_req |=> rd_valid_ff)
    else $error("read strobe missing after read request");

  no_read_valid_a: assert property ( // [RULE7]
    !rd_req |=> !rd_valid_ff)
    else $error("read strobe without read request");

  supply_summary_a: assert property ( // [RULE15]
    supply_fault_any |=> summary_ff[`PSEI_SUM_SUPPLY])
    else $error("supply fault not shown in summary");

  disc_summary_a: assert property ( // [RULE15]
    !disconnect_any |=> !summary_ff[`PSEI_SUM_DISC])
    else $error("disconnect summary set without source");

  mask_hold_a: assert property ( // [RULE2]
    !(wr_req && cmd_code == `PSEI_CMD_MASK) |=> $stable(irq_cause_mask_ff))
    else $error("mask changed without a mask write");

  line_idle_a: assert property ( // [RULE18]
    !(|(nxt_summary & irq_cause_mask_ff)) |=> int_n_ff)
    else $error("interrupt line asserted with no masked-in cause");

  class_mode_a: assert property ( // [RULE17]
    class_change_only_mode && class_changed_ch != `PSEI_CHAN_ZERO |=>
    |detect_class_events_ff[`PSEI_HI_HI:`PSEI_HI_LO])
    else $error("class change not latched in change-only mode");

  detect_cycle_a: assert property ( // [RULE17]
    !detect_change_only_mode && detect_cycle_ch != `PSEI_CHAN_ZERO |=>
    |detect_class_events_ff[`PSEI_LO_HI:`PSEI_LO_LO])
    else $error("detection cycle not latched");

  pe_event_set_a: assert property ( // [RULE12]
    power_enable_change_ch != `PSEI_CHAN_ZERO |=> |power_change_events_ff[`PSEI_LO_HI:`PSEI_LO_LO])
    else $error("power enable change not latched");
endmodule

// ===== psei_placeholder_unused.sv
// Intentionally empty companion file
`timescale 1ns/1ps

// ===== psei_host_model.sv
// Host-side model issuing single-byte accesses on the command port
`timescale 1ns/1ps
module psei_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output psei_pkg::psei_byte_t cmd_code,
  output psei_pkg::psei_byte_t cmd_wdata,
  input wire psei_pkg::psei_byte_t rd_data_ff,
  input wire logic rd_valid_ff
);
  import psei_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'hFF;
    cmd_wdata = 8'hFF;
  end
  // Host service order: summary first, then clearing aliases
  // Idle lines go to the inverse of the last value, so stale values never match
  task automatic access(input logic wr, input psei_byte_t code, input psei_byte_t wd,
      output psei_byte_t rd, output logic rv);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_write <= ~wr;
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    #1;
    rd = rd_data_ff;
    rv = rd_valid_ff;
  endtask
endmodule

// ===== tb_psei_event_irq.sv
// Self-checking bench for the event interrupt block
`timescale 1ns/1ps
module tb_psei_event_irq;
  import psei_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid, cmd_write, rd_valid_ff, int_n_ff;
  psei_byte_t cmd_code, cmd_wdata, rd_data_ff;
  psei_chan_t pe = 4'h0, pg = 4'h0, cc = 4'h0, ccg = 4'h0, dc = 4'h0, dcg = 4'h0, off = 4'h0;
  logic cm = 1'b0, dm = 1'b0, sf = 1'b0, st = 1'b0, oc = 1'b0, di = 1'b0;
  logic gate = 1'b1, sclr = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  always #2.5 sys_clk = ~sys_clk;
  psei_host_model u_psei_host_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
  psei_event_irq u_psei_event_irq (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .power_enable_change_ch(pe), .power_good_change_ch(pg), .class_cycle_ch(cc),
    .class_changed_ch(ccg), .detect_cycle_ch(dc), .detect_changed_ch(dcg),
    .channel_off_ch(off), .class_change_only_mode(cm), .detect_change_only_mode(dm),
    .supply_fault_any(sf), .start_fault_any(st), .overcurrent_fault_any(oc),
    .disconnect_any(di), .irq_global_gate(gate), .summary_clear(sclr),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .int_n_ff(int_n_ff));
  task automatic check(input psei_byte_t seen, input psei_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input psei_byte_t code, input psei_byte_t exp);
    psei_byte_t d;
    logic v;
    u_psei_host_model.access(1'b0, code, 8'h00, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask
  task automatic wr(input psei_byte_t code, input psei_byte_t wd);
    psei_byte_t d;
    logic v;
    u_psei_host_model.access(1'b1, code, wd, d, v);
  endtask
  task automatic line_is(input logic exp);
    check({7'h00, int_n_ff}, {7'h00, exp});
  endtask
  task automatic t_reset;
    rd(8'h01, 8'h80);
    rd(8'h00, 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h00);
    line_is(1'b1);
  endtask
  task automatic t_power;
    @(posedge sys_clk);
    pe <= 4'h4;
    pg <= 4'h2;
    @(posedge sys_clk);
    pe <= 4'h0;
    pg <= 4'h0;
    rd(8'h02, 8'h24);
    rd(8'h00, 8'h03);
    line_is(1'b1);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'hFF);
    line_is(1'b0);
    gate <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    line_is(1'b1);
    gate <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(8'h03, 8'h24);
    line_is(1'b1);
    rd(8'h02, 8'h00);
  endtask
  task automatic t_detect;
    @(posedge sys_clk);
    cc <= 4'h1;
    dc <= 4'h8;
    @(posedge sys_clk);
    cc <= 4'h0;
    dc <= 4'h0;
    rd(8'h04, 8'h18);
    rd(8'h00, 8'h18);
    off <= 4'h8;
    @(posedge sys_clk);
    off <= 4'h0;
    rd(8'h04, 8'h10);
    cm <= 1'b1;
    dm <= 1'b1;
    cc <= 4'h2;
    ccg <= 4'h4;
    dc <= 4'h1;
    dcg <= 4'h2;
    @(posedge sys_clk);
    {cc, ccg, dc, dcg} <= 16'h0000;
    rd(8'h05, 8'h52);
    rd(8'h04, 8'h00);
  endtask
  task automatic t_race;
    psei_byte_t d;
    logic v;
    fork
      u_psei_host_model.access(1'b0, 8'h03, 8'h00, d, v);
      begin
        @(posedge sys_clk);
        pe <= 4'h1;
        pg <= 4'h1;
        @(posedge sys_clk);
        pe <= 4'h0;
        pg <= 4'h0;
      end
    join
    check(d, 8'h00);
    rd(8'h02, 8'h11);
  endtask
  task automatic t_faults;
    {sf, st, oc, di} <= 4'hF;
    rd(8'h00, 8'hE7);
    line_is(1'b0);
    {sf, st, oc, di} <= 4'h0;
    sclr <= 1'b1;
    @(posedge sys_clk);
    sclr <= 1'b0;
    rd(8'h02, 8'h00);
    rd(8'h00, 8'h00);
    line_is(1'b1);
  endtask
  task automatic final_report;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_power();
    t_detect();
    t_race();
    t_faults();
    final_report();
  end
endmodule
